// >>> adc_link_pkg.sv
// shared constants for the serial converter link
package adc_link_pkg;
    localparam int WordBits = 16;
    localparam int ChanBits = 4;
    localparam int ResultBits = 10;
    localparam int PadBits = 6;
    localparam int ByteBits = 8;
    localparam int ChanMsb = 15;
    localparam int EocFallEdge = 10;
    localparam int SyncRiseEdge = 11;
    localparam int ConvClocks = 44;
    localparam logic [3:0] ChanLastInput = 4'ha;
    localparam logic [3:0] ChanHalfTest = 4'hb;
    localparam logic [3:0] ChanZeroTest = 4'hc;
    localparam logic [3:0] ChanFullTest = 4'hd;
    localparam logic [9:0] HalfScale = 10'h200;
    localparam logic [9:0] ZeroScale = 10'h000;
    localparam logic [9:0] FullScale = 10'h3ff;
    localparam logic [5:0] ResetConvDiv = 6'h10;
    localparam logic [3:0] SclkHalfDiv = 4'h5;
    localparam logic [5:0] ConvCountW = 6'h2c;
endpackage

// >>> adc_link_if.sv
// serial link between host controller and converter
`timescale 1ns/100ps
interface adc_link_if;
    logic serialClk;
    logic hostData;
    logic devData;
    logic selectN;
    logic convClk;
    logic convDoneN;
    modport device (input serialClk, input hostData, input selectN, input convClk,
                    output devData, output convDoneN);
    modport host (output serialClk, output hostData, output selectN, input devData,
                  input convClk, input convDoneN);
endinterface

// >>> adc_device.sv
// converter end: shift register, channel latch, conversion timer
// Notes on behaviour
// R1 - top nibble picks channel, rest ignored
// R2 - result in top ten bits, six zeros
// R3 - codes b c d give test levels
// R4 - sixteen clocks or two byte bursts
// R5 - result out while next address in
// R6 - host counts 44 conversion clocks
// R7 - host may use done output
// R8 - host shifts result right six
// R9 - codes 0 to a pick inputs
// R10 - done low tenth fall, high when ready
// R11 - conversion takes 44 conversion clocks
// R12 - host: eleventh rise before conversion ends
// R13 - host never sends codes e or f
// R14 - first result is previous channel's
`timescale 1ns/100ps
module adc_device
    import adc_link_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // link
    adc_link_if.device link,
    // analog samples
    input wire logic [10:0][9:0] analogSample,
    // status
    output logic [3:0] activeChan,
    output logic converting
);
    typedef enum logic [0:0] {Shift = 1'b0, Convert = 1'b1} devState_t;
    devState_t state_q, state_d;
    logic [2:0] sclkSync_q, sclkSync_d, selSync_q, selSync_d, cclkSync_q, cclkSync_d;
    logic [1:0] dinSync_q, dinSync_d;
    logic [15:0] outShift_q, outShift_d;
    logic [3:0] inShift_q, inShift_d;
    logic [4:0] bitCnt_q, bitCnt_d;
    logic [5:0] convCnt_q, convCnt_d;
    logic [3:0] chan_q, chan_d;
    logic [9:0] result_q, result_d;
    logic doneN_q, doneN_d, dout_q, dout_d, conv_q, conv_d;
    logic sclkRise, sclkFall, cclkRise, selHigh;
    logic [9:0] sampleMux;

    always_comb
    begin
        sclkSync_d = {sclkSync_q[1:0], link.serialClk};
        selSync_d = {selSync_q[1:0], link.selectN};
        cclkSync_d = {cclkSync_q[1:0], link.convClk};
        dinSync_d = {dinSync_q[0], link.hostData};
    end

    // only the second and third stages are looked at
    assign sclkRise = sclkSync_q[1] & ~sclkSync_q[2];
    assign sclkFall = ~sclkSync_q[1] & sclkSync_q[2];
    assign cclkRise = cclkSync_q[1] & ~cclkSync_q[2];
    assign selHigh = selSync_q[2];

    always_comb
    begin
        // reserved codes read as zero rather than past the input array
        sampleMux = ZeroScale;
        unique case (chan_q)
            ChanHalfTest: sampleMux = HalfScale; // R3
            ChanZeroTest: sampleMux = ZeroScale; // R3
            ChanFullTest: sampleMux = FullScale; // R3
            default:
            begin
                if (chan_q <= ChanLastInput)
                begin
                    sampleMux = analogSample[chan_q]; // R9
                end
            end
        endcase
    end

    always_comb
    begin
        state_d = state_q;
        outShift_d = outShift_q;
        inShift_d = inShift_q;
        bitCnt_d = bitCnt_q;
        convCnt_d = convCnt_q;
        chan_d = chan_q;
        result_d = result_q;
        doneN_d = doneN_q;
        dout_d = dout_q;
        conv_d = conv_q;
        if (selHigh)
        begin
            // deselect aborts the frame and restarts the bit count
            bitCnt_d = 5'h00;
            outShift_d = {result_q, {PadBits{1'b0}}}; // R2
            dout_d = result_q[ResultBits-1];
        end
        else
        begin
            unique case (state_q)
                Shift:
                begin
                    // sclk edges may pause between bytes, nothing times out
                    if (sclkRise && bitCnt_q < 5'(WordBits)) // R4
                    begin
                        // only the first four bits are kept, the low twelve are don't-care
                        if (bitCnt_q < 5'(ChanBits))
                        begin
                            inShift_d = {inShift_q[2:0], dinSync_q[1]}; // R1
                        end
                        bitCnt_d = bitCnt_q + 5'h01;
                    end
                    if (sclkFall && bitCnt_q != 5'h00)
                    begin
                        outShift_d = {outShift_q[14:0], 1'b0}; // R5
                        dout_d = outShift_q[14];
                        // a frame cut before the tenth fall leaves the old channel in place
                        if (bitCnt_q == 5'(EocFallEdge))
                        begin
                            chan_d = inShift_q; // R9
                            doneN_d = 1'b0; // R10
                            conv_d = 1'b1;
                            convCnt_d = 6'h00;
                            state_d = Convert;
                        end
                    end
                end
                Convert:
                begin
                    // pad bits only; the shift register is idle while converting
                    if (sclkRise && bitCnt_q < 5'(WordBits))
                    begin
                        bitCnt_d = bitCnt_q + 5'h01;
                    end
                    if (sclkFall && bitCnt_q < 5'(WordBits))
                    begin
                        dout_d = 1'b0; // R2
                    end
                end
            endcase
        end
        // the timer runs through a deselect, else a short select would stall it with done held low
        if (state_q == Convert && cclkRise)
        begin
            convCnt_d = convCnt_q + 6'h01;
            if (convCnt_q == ConvCountW - 6'h01) // R11
            begin
                // holds previous result until now, so next frame returns it
                result_d = sampleMux; // R14
                doneN_d = 1'b1; // R10
                conv_d = 1'b0;
                state_d = Shift;
            end
        end
    end

    // synchroniser group, idle levels at reset so no false edge follows it
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sclkSync_q <= 3'h0;
            selSync_q <= 3'h7;
            cclkSync_q <= 3'h0;
            dinSync_q <= 2'h0;
        end
        else
        begin
            sclkSync_q <= sclkSync_d;
            selSync_q <= selSync_d;
            cclkSync_q <= cclkSync_d;
            dinSync_q <= dinSync_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_q <= Shift;
            outShift_q <= 16'h0000;
            inShift_q <= 4'h0;
            bitCnt_q <= 5'h00;
            convCnt_q <= 6'h00;
            chan_q <= 4'h0;
            result_q <= 10'h000;
            doneN_q <= 1'b1;
            dout_q <= 1'b0;
            conv_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            outShift_q <= outShift_d;
            inShift_q <= inShift_d;
            bitCnt_q <= bitCnt_d;
            convCnt_q <= convCnt_d;
            chan_q <= chan_d;
            result_q <= result_d;
            doneN_q <= doneN_d;
            dout_q <= dout_d;
            conv_q <= conv_d;
        end
    end

    // link outputs straight from flops
    assign link.devData = dout_q;
    assign link.convDoneN = doneN_q;
    assign activeChan = chan_q;
    assign converting = conv_q;
endmodule

// >>> adc_host.sv
// host end: issues one sixteen-bit frame per accepted request and returns the result
`timescale 1ns/100ps
module adc_host
    import adc_link_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // link
    adc_link_if.host link,
    // request
    input wire logic reqValid,
    input wire logic [3:0] reqChan,
    input wire logic splitBytes,
    input wire logic useDone,
    // answer
    output logic respValid,
    output logic [15:0] respWord,
    output logic [9:0] respCode,
    output logic reqBusy,
    output logic reqReject
);
    typedef enum logic [1:0] {Idle = 2'b00, Xfer = 2'b01, Pause = 2'b10, Wait = 2'b11} hostState_t;
    hostState_t state_q, state_d;
    logic [1:0] doneSync_q, doneSync_d, dinSync_q, dinSync_d, cclkSync_q, cclkSync_d;
    logic doneLast_q, doneLast_d, cclkLast_q, cclkLast_d;
    logic [3:0] div_q, div_d;
    logic [4:0] bit_q, bit_d;
    logic [15:0] txWord_q, txWord_d, rxWord_q, rxWord_d;
    logic [5:0] cnt_q, cnt_d;
    logic sclk_q, sclk_d, sel_q, sel_d, dout_q, dout_d, useDone_q, useDone_d;
    logic respValid_q, respValid_d, busy_q, busy_d, rej_q, rej_d;
    logic [9:0] code_q, code_d;
    logic tick;

    assign tick = (div_q == SclkHalfDiv - 4'h1);

    always_comb
    begin
        doneSync_d = {doneSync_q[0], link.convDoneN};
        dinSync_d = {dinSync_q[0], link.devData};
        cclkSync_d = {cclkSync_q[0], link.convClk};
        doneLast_d = doneSync_q[1];
        cclkLast_d = cclkSync_q[1];
        state_d = state_q;
        div_d = tick ? 4'h0 : div_q + 4'h1;
        bit_d = bit_q;
        txWord_d = txWord_q;
        rxWord_d = rxWord_q;
        cnt_d = cnt_q;
        sclk_d = sclk_q;
        sel_d = sel_q;
        dout_d = dout_q;
        useDone_d = useDone_q;
        respValid_d = 1'b0;
        busy_d = busy_q;
        rej_d = 1'b0;
        code_d = code_q;
        unique case (state_q)
            Idle:
            begin
                if (reqValid && reqChan > ChanFullTest)
                begin
                    rej_d = 1'b1; // R13
                end
                else if (reqValid)
                begin
                    // channel in top nibble, low bits sent as zero
                    txWord_d = {reqChan, 12'h000}; // R1
                    useDone_d = useDone;
                    bit_d = 5'h00;
                    sel_d = 1'b0;
                    busy_d = 1'b1;
                    div_d = 4'h0;
                    dout_d = reqChan[3];
                    state_d = Xfer;
                end
            end
            Xfer:
            begin
                // whole frame clocked quickly, eleventh rise precedes conversion end
                if (tick) // R12
                begin
                    sclk_d = ~sclk_q;
                    if (!sclk_q)
                    begin
                        bit_d = bit_q + 5'h01;
                    end
                    else
                    begin
                        // sampled at the fall: the round trip through both synchronisers outlasts half a period
                        rxWord_d = {rxWord_q[14:0], dinSync_q[1]}; // R5
                        txWord_d = {txWord_q[14:0], 1'b0};
                        dout_d = txWord_q[14];
                        if (bit_q == 5'(ByteBits) && splitBytes)
                        begin
                            state_d = Pause; // R4
                            cnt_d = 6'h00;
                        end
                        else if (bit_q == 5'(WordBits))
                        begin
                            cnt_d = 6'h00;
                            state_d = Wait;
                        end
                    end
                end
            end
            Pause:
            begin
                if (tick)
                begin
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q == ResetConvDiv)
                    begin
                        state_d = Xfer; // R4
                    end
                end
            end
            Wait:
            begin
                if (cnt_q == 6'h00)
                begin
                    // result belongs to the channel sent in the prior frame
                    code_d = rxWord_q[15:6]; // R8
                    respValid_d = 1'b1; // R14
                    cnt_d = 6'h01;
                end
                if (useDone_q)
                begin
                    if (doneSync_q[1] && !doneLast_q)
                    begin
                        busy_d = 1'b0; // R7
                        sel_d = 1'b1;
                        state_d = Idle;
                    end
                end
                else if (cclkSync_q[1] && !cclkLast_q)
                begin
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q == ConvCountW) // R6
                    begin
                        busy_d = 1'b0;
                        sel_d = 1'b1;
                        state_d = Idle;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_q <= Idle;
            doneSync_q <= 2'h3;
            dinSync_q <= 2'h0;
            cclkSync_q <= 2'h0;
            doneLast_q <= 1'b1;
            cclkLast_q <= 1'b0;
            div_q <= 4'h0;
            bit_q <= 5'h00;
            txWord_q <= 16'h0000;
            rxWord_q <= 16'h0000;
            cnt_q <= 6'h00;
            sclk_q <= 1'b0;
            sel_q <= 1'b1;
            dout_q <= 1'b0;
            useDone_q <= 1'b0;
            respValid_q <= 1'b0;
            busy_q <= 1'b0;
            rej_q <= 1'b0;
            code_q <= 10'h000;
        end
        else
        begin
            state_q <= state_d;
            doneSync_q <= doneSync_d;
            dinSync_q <= dinSync_d;
            cclkSync_q <= cclkSync_d;
            doneLast_q <= doneLast_d;
            cclkLast_q <= cclkLast_d;
            div_q <= div_d;
            bit_q <= bit_d;
            txWord_q <= txWord_d;
            rxWord_q <= rxWord_d;
            cnt_q <= cnt_d;
            sclk_q <= sclk_d;
            sel_q <= sel_d;
            dout_q <= dout_d;
            useDone_q <= useDone_d;
            respValid_q <= respValid_d;
            busy_q <= busy_d;
            rej_q <= rej_d;
            code_q <= code_d;
        end
    end

    assign link.serialClk = sclk_q;
    assign link.selectN = sel_q;
    assign link.hostData = dout_q;
    assign respValid = respValid_q;
    assign respWord = rxWord_q;
    assign respCode = code_q;
    assign reqBusy = busy_q;
    assign reqReject = rej_q;
endmodule

// >>> adc_link_assertions.sv
// concurrent checks on the converter link wires
`timescale 1ns/100ps
module adc_link_assertions
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // link wires
    input wire logic serialClk,
    input wire logic hostData,
    input wire logic devData,
    input wire logic selectN,
    input wire logic convClk,
    input wire logic convDoneN
);
    logic sclk_q;
    logic cclk_q;
    logic [4:0] rise_q;
    logic [4:0] fall_q;
    logic [3:0] code_q;
    logic [6:0] conv_q;
    logic [10:0] low_q;
    wire sRise = serialClk && !sclk_q;
    wire sFall = !serialClk && sclk_q;

    // raw wire counts; the device syncs its inputs, so spans below allow a rise of slack
    always_ff @(posedge clk)
    begin
        sclk_q <= serialClk;
        cclk_q <= convClk;
        rise_q <= (srst || selectN) ? 5'h00 : rise_q + 5'(sRise);
        fall_q <= (srst || selectN) ? 5'h00 : fall_q + 5'(sFall);
        code_q <= (sRise && !selectN) ? {code_q[2:0], hostData} : code_q;
        conv_q <= (srst || convDoneN) ? 7'h00 : conv_q + 7'(convClk && !cclk_q);
        low_q <= (srst || convDoneN) ? 11'h000 : low_q + 11'h001;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    chk_clock_parked: assert property (selectN && $past(selectN) |-> !serialClk)
        else $error("serial clock moves outside a frame");
    chk_frame_sixteen: assert property ($rose(selectN) |-> rise_q == 5'h10)
        else $error("frame ended without sixteen clocks");
    chk_tail_zero: assert property (sRise && !selectN && rise_q >= 5'h04 |-> !hostData)
        else $error("host sent ones below the channel nibble");
    chk_pad_zeros: assert property (sRise && !selectN && rise_q >= 5'h0a |-> !devData)
        else $error("device pad bits not zero");
    chk_code_legal: assert property (sRise && !selectN && rise_q == 5'h03 |-> {code_q[2:0], hostData} < 4'he)
        else $error("reserved channel code sent");
    chk_done_tenth: assert property ($fell(convDoneN) |-> fall_q == 5'h0a)
        else $error("done output fell away from the tenth falling edge");
    chk_rise_early: assert property (sRise && !selectN && rise_q == 5'h0a |-> !convDoneN)
        else $error("eleventh serial clock rise after conversion end");
    chk_conv_span: assert property ($rose(convDoneN) |-> conv_q >= 7'h2b && conv_q <= 7'h2d)
        else $error("conversion span not 44 conversion clocks");
    chk_done_bounded: assert property (!convDoneN |-> low_q < 11'h3e8)
        else $error("done output stuck low");
endmodule

// >>> serial_adc_word_format_tb.sv
// self-checking bench for the two link ends joined back to back
`timescale 1ns/100ps
module serial_adc_word_format_tb
    import adc_link_pkg::*;
;
    logic clk, srst, reqValid, splitBytes, useDone, respValid, reqBusy, reqReject, converting, sclk_q;
    logic [3:0] reqChan, activeChan;
    logic [10:0][9:0] analogSample;
    logic [15:0] respWord, hostW_q, devW_q;
    logic [9:0] respCode, prev, nxt;
    logic [4:0] bits_q;
    int fails, checkCount;

    adc_link_if link();
    adc_device adc_device_inst (.clk(clk), .srst(srst), .link(link), .analogSample(analogSample),
        .activeChan(activeChan), .converting(converting));
    adc_host adc_host_inst (.clk(clk), .srst(srst), .link(link), .reqValid(reqValid), .reqChan(reqChan),
        .splitBytes(splitBytes), .useDone(useDone), .respValid(respValid), .respWord(respWord),
        .respCode(respCode), .reqBusy(reqBusy), .reqReject(reqReject));
    adc_link_assertions adc_link_assertions_inst (.clk(clk), .srst(srst), .serialClk(link.serialClk),
        .hostData(link.hostData), .devData(link.devData), .selectN(link.selectN), .convClk(link.convClk),
        .convDoneN(link.convDoneN));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // conversion clock runs free with a phase unrelated to clk
    initial
    begin
        link.convClk = 1'b0;
        #13;
        forever #40 link.convClk = ~link.convClk;
    end

    // wire monitor: both directions sampled on serial clock rises
    always @(posedge clk)
    begin
        sclk_q <= link.serialClk;
        if (link.selectN)
            bits_q <= 5'h00;
        else if (link.serialClk && !sclk_q)
        begin
            bits_q <= bits_q + 5'h01;
            hostW_q <= {hostW_q[14:0], link.hostData};
            devW_q <= {devW_q[14:0], link.devData};
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        checkCount++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [9:0] expOf(input logic [3:0] ch);
        case (ch)
            4'hb: return 10'h200;
            4'hc: return 10'h000;
            4'hd: return 10'h3ff;
            default: return analogSample[ch];
        endcase
    endfunction

    task automatic xfer(input logic [3:0] ch, input logic sp, input logic ud, input logic [9:0] exp);
        int n;
        bit late;
        @(posedge clk);
        reqValid <= 1'b1;
        reqChan <= ch;
        splitBytes <= sp;
        useDone <= ud;
        @(posedge clk);
        reqValid <= 1'b0;
        n = 0;
        while (respValid !== 1'b1 && n < 4000)
        begin
            @(negedge clk);
            n++;
        end
        cmp(16'(n < 4000), 16'h0001, "answer arrived");
        late = (n >= 4000);
        cmp(respWord, {exp, 6'h00}, "result word");
        cmp({6'h00, respCode}, {6'h00, exp}, "result code");
        cmp(hostW_q, {ch, 12'h000}, "address on wire");
        cmp(devW_q, {exp, 6'h00}, "result on wire");
        cmp({11'h000, bits_q}, 16'h0010, "clocks in frame");
        cmp({15'h0000, converting}, 16'h0001, "converting after frame");
        cmp({15'h0000, link.convDoneN}, 16'h0000, "done low after tenth fall");
        n = 0;
        while (reqBusy !== 1'b0 && n < 4000)
        begin
            @(negedge clk);
            n++;
        end
        cmp(16'(n < 4000), 16'h0001, "busy released");
        cmp({12'h000, activeChan}, {12'h000, ch}, "active channel");
        cmp({15'h0000, converting}, 16'h0000, "conversion finished");
        cmp({15'h0000, link.convDoneN}, 16'h0001, "done high when ready");
        if (n >= 4000 || late)
            final_report();
    endtask

    task automatic refuse(input logic [3:0] ch);
        logic seen;
        seen = 1'b0;
        @(posedge clk);
        reqValid <= 1'b1;
        reqChan <= ch;
        @(posedge clk);
        reqValid <= 1'b0;
        repeat (4)
        begin
            @(negedge clk);
            seen = seen | (reqReject === 1'b1);
            cmp({15'h0000, link.selectN}, 16'h0001, "no frame on refusal");
        end
        cmp({15'h0000, seen}, 16'h0001, "refusal pulse");
    endtask

    initial
    begin
        srst = 1'b1;
        reqValid = 1'b0;
        reqChan = 4'h0;
        splitBytes = 1'b0;
        useDone = 1'b0;
        fails = 0;
        checkCount = 0;
        for (int i = 0; i < 11; i++)
            analogSample[i] = 10'h05d * 10'(i) + 10'h011;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        prev = 10'h000;
        // every legal code, both frame forms and both timing modes
        for (int k = 0; k < 14; k++)
        begin
            nxt = expOf(4'(k));
            xfer(4'(k), k[0], k[1], prev);
            prev = nxt;
        end
        refuse(4'he);
        refuse(4'hf);
        xfer(4'h5, 1'b1, 1'b1, prev);
        // second reset in mid-run returns the reset result first
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        xfer(4'h0, 1'b0, 1'b0, 10'h000);
        final_report();
    end
endmodule
